// ### verilog/ssr_top.sv
// register port over the two-wire bus, configuration registers and spread ramp
// Function
// - triangle period is twice step count times divider reference ticks
// - peak numerator drop equals signed step size times step count
// - 9-bit step count: upper eight bits, then bit 7 of next register
// - step size is 8-bit two's complement, only -128 to 0 valid
// - update divider is 7 bits in bits 6..0, valid 2 to 127
// - 12-bit numerator: upper byte, then bits 7..4 of next register
// - 12-bit divisor: bits 3..0 shared register, low byte following
// - second loop integer ratio in bits 5..0 at 0x1C
// - bandwidth 50 kHz normally, 125 kHz while spreading
// - wide-loop pin raises spreading bandwidth to 250 kHz
// - write: start, address with 0, subaddress, data bytes, stop; all acked
// - read: address, subaddress, repeated start, address with 1, data
// - register 0x40 holds host-settings enable at bit 1
// - register 0x1F carries reacquire request in bit 0
// - register 0x11 holds drain enable and both channel power-downs
// - register 0x18 holds first loop integer ratio in bits 5..0
// - spread enable pin puts the second loop in triangular spread mode
// - ramp numerator down and up from nominal by step size each update
// - updates at reference rate over divider; count updates per half
// - changed spread settings act only after the enable pin toggles
`timescale 1ns/10ps
`default_nettype none
module ssr_top #(
	// bus address; value is arbitrary
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	// two-wire register port
	input  wire logic              scl,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	// pins
	input  wire logic              ref_div_clk,
	input  wire logic              spread_enable_pin,
	input  wire logic              wide_loop_select,
	// first loop and channels
	output logic [5:0]             pll1_feedback_integer,
	output logic                   channel0_powerdown,
	output logic                   channel1_powerdown,
	output logic                   charge_drain_enable,
	// second loop
	output logic [5:0]             pll2_feedback_integer,
	output logic [11:0]            sdm_numerator,
	output logic [11:0]            sdm_divisor,
	output ssr_pkg::ssr_bw_t       loop_bandwidth,
	output logic                   spread_active,
	// control
	output logic                   host_settings_enable,
	output logic                   reacquire_request
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		ssr_pkg::ssr_i2c_st_t st;
		ssr_pkg::ssr_i2c_st_t after;
		logic [3:0]           bitcnt;
		logic [7:0]           shreg;
		logic [7:0]           sub;
		logic                 mnack;
		logic                 oe;
		logic                 scl_d;
		logic                 sda_d;
		logic                 ref_d;
		logic                 tick;
		logic                 reacq;
		ssr_pkg::ssr_bw_t     bw;
		ssr_pkg::ssr_regs_t   regs;
	} ssr_top_state_t;

	ssr_top_state_t r;
	ssr_top_state_t next_r;

	logic [4:0]             pins_s;
	logic                   scl_s;
	logic                   sda_s;
	logic                   ref_s;
	logic                   spread_s;
	logic                   wide_s;
	logic                   ramp_active;
	logic [11:0]            ramp_num;
	ssr_pkg::ssr_ramp_cfg_t ramp_cfg;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, link clock sampled like any pin

	ssr_sync #(
		.W(5)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.async_in({scl, sda_i, ref_div_clk, spread_enable_pin, wide_loop_select}),
		.sync_out(pins_s)
	);

	assign scl_s    = pins_s[4];
	assign sda_s    = pins_s[3];
	assign ref_s    = pins_s[2];
	assign spread_s = pins_s[1];
	assign wide_s   = pins_s[0];

	////////////////////////////////////////////////////////////////////////////
	// register images

	function automatic logic [7:0] read_reg(input ssr_pkg::ssr_regs_t rg, input logic [7:0] a);
		logic [7:0] d;
		d = ssr_pkg::READ_UNMAPPED;
		case (a)
			ssr_pkg::ADDR_CHANNEL_POWER_DRAIN:  d = {5'h00, rg.power_drain};
			ssr_pkg::ADDR_PLL1_FEEDBACK_INT:    d = {2'h0, rg.pll1_fb};
			ssr_pkg::ADDR_NUMERATOR_HI:         d = rg.numerator_hi;
			ssr_pkg::ADDR_NUMERATOR_LO_DIV_HI:  d = rg.numerator_lo_divisor_hi;
			ssr_pkg::ADDR_DIVISOR_LO:           d = rg.divisor_lo;
			ssr_pkg::ADDR_PLL2_FEEDBACK_INT:    d = {2'h0, rg.pll2_fb};
			ssr_pkg::ADDR_SPREAD_INCREMENT:     d = rg.increment;
			ssr_pkg::ADDR_SPREAD_STEP_COUNT_HI: d = rg.step_count_hi;
			ssr_pkg::ADDR_SPREAD_COUNT_LO_RATE: d = rg.count_lo_rate_div;
			ssr_pkg::ADDR_HOST_PROGRAM_ENABLE:  d = {6'h00, rg.host_en, 1'b0};
			default:                            d = ssr_pkg::READ_UNMAPPED;
		endcase
		return d;
	endfunction : read_reg

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic [7:0] rd;
		scl_rise = scl_s && !r.scl_d;
		scl_fall = !scl_s && r.scl_d;
		start_c  = scl_s && r.scl_d && r.sda_d && !sda_s;
		stop_c   = scl_s && r.scl_d && !r.sda_d && sda_s;
		rd       = 8'h00;

		next_r       = r;
		next_r.scl_d = scl_s;
		next_r.sda_d = sda_s;
		next_r.ref_d = ref_s;
		next_r.tick  = ref_s && !r.ref_d;
		next_r.reacq = 1'b0;

		// bandwidth follows the pins, not any register
		if (!spread_s) begin
			next_r.bw = ssr_pkg::BW_50K;
		end else if (wide_s) begin
			next_r.bw = ssr_pkg::BW_250K;
		end else begin
			next_r.bw = ssr_pkg::BW_125K;
		end

		if (start_c) begin
			// a repeated start reopens the address phase
			next_r.st     = ssr_pkg::ST_ADDR;
			next_r.bitcnt = 4'h0;
			next_r.oe     = 1'b0;
		end else if (stop_c) begin
			next_r.st = ssr_pkg::ST_IDLE;
			next_r.oe = 1'b0;
		end else if (scl_rise) begin
			case (r.st)
				ssr_pkg::ST_ADDR,
				ssr_pkg::ST_SUB,
				ssr_pkg::ST_WDATA: begin
					next_r.shreg  = {r.shreg[6:0], sda_s};
					next_r.bitcnt = r.bitcnt + 4'h1;
				end
				ssr_pkg::ST_MACK: begin
					next_r.mnack = sda_s;
				end
				default: begin
					next_r.mnack = r.mnack;
				end
			endcase
		end else if (scl_fall) begin
			case (r.st)
				ssr_pkg::ST_ADDR: begin
					if (r.bitcnt == 4'h8) begin
						next_r.bitcnt = 4'h0;
						if (r.shreg[7:1] == DEV_ADDR) begin
							next_r.oe    = 1'b1;
							next_r.st    = ssr_pkg::ST_ACK;
							next_r.after = r.shreg[0] ? ssr_pkg::ST_RDATA : ssr_pkg::ST_SUB;
						end else begin
							next_r.st = ssr_pkg::ST_IDLE;
						end
					end
				end
				ssr_pkg::ST_SUB: begin
					if (r.bitcnt == 4'h8) begin
						next_r.bitcnt = 4'h0;
						next_r.sub    = r.shreg;
						next_r.oe     = 1'b1;
						next_r.st     = ssr_pkg::ST_ACK;
						next_r.after  = ssr_pkg::ST_WDATA;
					end
				end
				ssr_pkg::ST_WDATA: begin
					if (r.bitcnt == 4'h8) begin
						next_r.bitcnt = 4'h0;
						next_r.oe     = 1'b1;
						next_r.st     = ssr_pkg::ST_ACK;
						next_r.after  = ssr_pkg::ST_WDATA;
						next_r.sub    = r.sub + 8'h01;
						// reserved bits are dropped, so they always read as zero
						case (r.sub)
							ssr_pkg::ADDR_CHANNEL_POWER_DRAIN: begin
								next_r.regs.power_drain = r.shreg[ssr_pkg::BIT_CHARGE_DRAIN:0];
							end
							ssr_pkg::ADDR_PLL1_FEEDBACK_INT: begin
								next_r.regs.pll1_fb = r.shreg[ssr_pkg::FEEDBACK_INT_MSB:0];
							end
							ssr_pkg::ADDR_NUMERATOR_HI: begin
								next_r.regs.numerator_hi = r.shreg;
							end
							ssr_pkg::ADDR_NUMERATOR_LO_DIV_HI: begin
								next_r.regs.numerator_lo_divisor_hi = r.shreg;
							end
							ssr_pkg::ADDR_DIVISOR_LO: begin
								next_r.regs.divisor_lo = r.shreg;
							end
							ssr_pkg::ADDR_PLL2_FEEDBACK_INT: begin
								next_r.regs.pll2_fb = r.shreg[ssr_pkg::FEEDBACK_INT_MSB:0];
							end
							ssr_pkg::ADDR_ACQUISITION_TRIGGER: begin
								// self-clearing: nothing stored
								next_r.reacq = r.shreg[ssr_pkg::BIT_REACQUIRE_REQUEST];
							end
							ssr_pkg::ADDR_SPREAD_INCREMENT: begin
								next_r.regs.increment = r.shreg;
							end
							ssr_pkg::ADDR_SPREAD_STEP_COUNT_HI: begin
								next_r.regs.step_count_hi = r.shreg;
							end
							ssr_pkg::ADDR_SPREAD_COUNT_LO_RATE: begin
								next_r.regs.count_lo_rate_div = r.shreg;
							end
							ssr_pkg::ADDR_HOST_PROGRAM_ENABLE: begin
								next_r.regs.host_en = r.shreg[ssr_pkg::BIT_HOST_SETTINGS_ENABLE];
							end
							default: begin
								next_r.regs = r.regs;
							end
						endcase
					end
				end
				ssr_pkg::ST_ACK: begin
					next_r.oe = 1'b0;
					next_r.st = r.after;
					if (r.after == ssr_pkg::ST_RDATA) begin
						rd            = read_reg(r.regs, r.sub);
						next_r.oe     = !rd[7];
						next_r.shreg  = {rd[6:0], 1'b0};
						next_r.bitcnt = 4'h1;
					end
				end
				ssr_pkg::ST_RDATA: begin
					if (r.bitcnt == 4'h8) begin
						// release for the master's acknowledge
						next_r.oe = 1'b0;
						next_r.st = ssr_pkg::ST_MACK;
					end else begin
						next_r.oe     = !r.shreg[7];
						next_r.shreg  = {r.shreg[6:0], 1'b0};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
				end
				ssr_pkg::ST_MACK: begin
					if (r.mnack) begin
						// a not-acknowledge ends the read; wait for stop
						next_r.st = ssr_pkg::ST_IDLE;
					end else begin
						next_r.sub    = r.sub + 8'h01;
						rd            = read_reg(r.regs, r.sub + 8'h01);
						next_r.oe     = !rd[7];
						next_r.shreg  = {rd[6:0], 1'b0};
						next_r.bitcnt = 4'h1;
						next_r.st     = ssr_pkg::ST_RDATA;
					end
				end
				default: begin
					next_r.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r                              <= '0;
			r.st                           <= ssr_pkg::ST_IDLE;
			r.after                        <= ssr_pkg::ST_IDLE;
			r.bw                           <= ssr_pkg::BW_50K;
			r.scl_d                        <= 1'b1;
			r.sda_d                        <= 1'b1;
			r.regs.numerator_hi            <= ssr_pkg::RST_REG_BYTE;
			r.regs.numerator_lo_divisor_hi <= ssr_pkg::RST_REG_BYTE;
			r.regs.divisor_lo              <= ssr_pkg::RST_REG_BYTE;
			r.regs.increment               <= ssr_pkg::RST_REG_BYTE;
			r.regs.step_count_hi           <= ssr_pkg::RST_REG_BYTE;
			r.regs.count_lo_rate_div       <= ssr_pkg::RST_REG_BYTE;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// spread ramp

	always_comb begin
		ramp_cfg.step_count = {r.regs.step_count_hi, r.regs.count_lo_rate_div[ssr_pkg::BIT_STEP_COUNT_LSB]};
		ramp_cfg.increment  = r.regs.increment;
		ramp_cfg.rate_div   = r.regs.count_lo_rate_div[ssr_pkg::RATE_DIV_MSB:0];
		ramp_cfg.numerator  = {r.regs.numerator_hi, r.regs.numerator_lo_divisor_hi[7:4]};
	end

	ssr_ramp u_ramp (
		.clk_sys      (clk_sys),
		.nrst         (nrst),
		.spread_on    (spread_s),
		.ref_tick     (r.tick),
		.cfg          (ramp_cfg),
		.spread_active(ramp_active),
		.numerator_out(ramp_num)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// open drain: only ever pulls low
	assign sda_o                 = 1'b0;
	assign sda_oe                = r.oe;
	assign pll1_feedback_integer = r.regs.pll1_fb;
	assign channel0_powerdown    = r.regs.power_drain[ssr_pkg::BIT_CHANNEL0_POWERDOWN];
	assign channel1_powerdown    = r.regs.power_drain[ssr_pkg::BIT_CHANNEL1_POWERDOWN];
	assign charge_drain_enable   = r.regs.power_drain[ssr_pkg::BIT_CHARGE_DRAIN];
	assign pll2_feedback_integer = r.regs.pll2_fb;
	assign sdm_numerator         = ramp_num;
	assign sdm_divisor           = {r.regs.numerator_lo_divisor_hi[3:0], r.regs.divisor_lo};
	assign loop_bandwidth        = r.bw;
	assign spread_active         = ramp_active;
	assign host_settings_enable  = r.regs.host_en;
	assign reacquire_request     = r.reacq;

endmodule : ssr_top
`default_nettype wire

// ### shared/ssr_pkg.sv
// shared constants and types of the spread-spectrum ramp and its register port
package ssr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register subaddresses
	localparam logic [7:0] ADDR_CHANNEL_POWER_DRAIN = 8'h11;
	localparam logic [7:0] ADDR_PLL1_FEEDBACK_INT   = 8'h18;
	localparam logic [7:0] ADDR_NUMERATOR_HI        = 8'h19;
	localparam logic [7:0] ADDR_NUMERATOR_LO_DIV_HI = 8'h1A;
	localparam logic [7:0] ADDR_DIVISOR_LO          = 8'h1B;
	localparam logic [7:0] ADDR_PLL2_FEEDBACK_INT   = 8'h1C;
	localparam logic [7:0] ADDR_ACQUISITION_TRIGGER = 8'h1F;
	localparam logic [7:0] ADDR_SPREAD_INCREMENT    = 8'h2A;
	localparam logic [7:0] ADDR_SPREAD_STEP_COUNT_HI = 8'h2B;
	localparam logic [7:0] ADDR_SPREAD_COUNT_LO_RATE = 8'h2C;
	localparam logic [7:0] ADDR_HOST_PROGRAM_ENABLE = 8'h40;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIT_HOST_SETTINGS_ENABLE = 1;
	localparam int BIT_REACQUIRE_REQUEST    = 0;
	localparam int BIT_CHARGE_DRAIN         = 2;
	localparam int BIT_CHANNEL1_POWERDOWN   = 1;
	localparam int BIT_CHANNEL0_POWERDOWN   = 0;
	localparam int BIT_STEP_COUNT_LSB       = 7;
	localparam int FEEDBACK_INT_MSB         = 5;
	localparam int RATE_DIV_MSB             = 6;

	////////////////////////////////////////////////////////////////////////////
	// reset and unmapped-read values
	localparam logic [7:0]  RST_REG_BYTE  = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED = 8'h00;
	localparam logic [17:0] RST_OFFSET    = 18'h00000;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_SUB   = 3'h2,
		ST_WDATA = 3'h3,
		ST_ACK   = 3'h4,
		ST_RDATA = 3'h5,
		ST_MACK  = 3'h6
	} ssr_i2c_st_t;

	typedef enum logic [1:0] {
		BW_50K  = 2'h0,
		BW_125K = 2'h1,
		BW_250K = 2'h2
	} ssr_bw_t;

	typedef struct packed {
		logic [2:0] power_drain;
		logic [5:0] pll1_fb;
		logic [7:0] numerator_hi;
		logic [7:0] numerator_lo_divisor_hi;
		logic [7:0] divisor_lo;
		logic [5:0] pll2_fb;
		logic       host_en;
		logic [7:0] increment;
		logic [7:0] step_count_hi;
		logic [7:0] count_lo_rate_div;
	} ssr_regs_t;

	typedef struct packed {
		logic [8:0]  step_count;
		logic [7:0]  increment;
		logic [6:0]  rate_div;
		logic [11:0] numerator;
	} ssr_ramp_cfg_t;

endpackage : ssr_pkg

// ### verilog/ssr_sync.sv
// two-flop synchronisers for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module ssr_sync #(
	parameter int W = 5
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ssr_sync_state_t;

	ssr_sync_state_t r;
	ssr_sync_state_t next_r;

	// first stage feeds only the second stage
	always_comb begin
		next_r    = r;
		next_r.s1 = async_in;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sync_out = r.s2;

endmodule : ssr_sync
`default_nettype wire

// ### verilog/ssr_ramp.sv
// triangular fractional-word ramp for the sigma-delta numerator
`timescale 1ns/10ps
`default_nettype none
module ssr_ramp (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	// control
	input  wire logic                  spread_on,
	input  wire logic                  ref_tick,
	input  wire ssr_pkg::ssr_ramp_cfg_t cfg,
	// result
	output logic                       spread_active,
	output logic [11:0]                numerator_out
);

	typedef struct packed {
		ssr_pkg::ssr_ramp_cfg_t cfg;
		logic                   en_d;
		logic                   active;
		logic [6:0]             div_cnt;
		logic [8:0]             step_cnt;
		logic                   down;
		logic [17:0]            offset;
		logic [11:0]            num;
	} ssr_ramp_state_t;

	ssr_ramp_state_t r;
	ssr_ramp_state_t next_r;

	always_comb begin
		logic [17:0] sum;
		sum         = 18'h00000;
		next_r      = r;
		next_r.en_d = spread_on;
		if (spread_on && !r.en_d) begin
			// new settings only land on the enable edge
			next_r.cfg      = cfg;
			next_r.active   = 1'b1;
			next_r.div_cnt  = 7'h00;
			next_r.step_cnt = 9'h000;
			next_r.down     = 1'b1;
			next_r.offset   = ssr_pkg::RST_OFFSET;
		end else if (!spread_on) begin
			next_r.active = 1'b0;
			next_r.offset = ssr_pkg::RST_OFFSET;
		end else if (ref_tick) begin
			// a divider below 2 degenerates to one tick per update
			if (({1'b0, r.div_cnt} + 8'h01) >= {1'b0, r.cfg.rate_div}) begin
				next_r.div_cnt = 7'h00;
				if (r.down) begin
					next_r.offset = r.offset + {{10{r.cfg.increment[7]}}, r.cfg.increment};
				end else begin
					next_r.offset = r.offset - {{10{r.cfg.increment[7]}}, r.cfg.increment};
				end
				// count updates per half; peak offset is increment times count
				if (({1'b0, r.step_cnt} + 10'h001) >= {1'b0, r.cfg.step_count}) begin
					next_r.step_cnt = 9'h000;
					next_r.down     = !r.down;
				end else begin
					next_r.step_cnt = r.step_cnt + 9'h001;
				end
			end else begin
				next_r.div_cnt = r.div_cnt + 7'h01;
			end
		end
		// clamp so an out-of-range increment never wraps the word
		sum = {6'h00, next_r.cfg.numerator} + next_r.offset;
		if (!next_r.active) begin
			next_r.num = cfg.numerator;
		end else if (sum[17]) begin
			next_r.num = 12'h000;
		end else if (sum[16:12] != 5'h00) begin
			next_r.num = 12'hFFF;
		end else begin
			next_r.num = sum[11:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign spread_active = r.active;
	assign numerator_out = r.num;

endmodule : ssr_ramp
`default_nettype wire

// ### verification/ssr_top_sva.sv
// assertions on the ports of the spread ramp register block
`timescale 1ns/10ps
`default_nettype none
module ssr_top_sva (
	// clock and reset
	input wire logic             clk_sys,
	input wire logic             nrst,
	// bus pins
	input wire logic             scl,
	input wire logic             sda_oe,
	// pins and results
	input wire logic             spread_enable_pin,
	input wire logic             wide_loop_select,
	input wire logic [11:0]      sdm_numerator,
	input wire ssr_pkg::ssr_bw_t loop_bandwidth,
	input wire logic             spread_active,
	input wire logic             reacquire_request
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////
	// five cycles cover the two sync flops plus the output register
	a_bw_normal: assert property (!spread_enable_pin [*5] |-> loop_bandwidth == ssr_pkg::BW_50K)
		else $error("bandwidth not normal while spreading is off");
	a_bw_spread: assert property ((spread_enable_pin && !wide_loop_select) [*5] |-> loop_bandwidth == ssr_pkg::BW_125K)
		else $error("bandwidth not raised while spreading");
	a_bw_wide: assert property ((spread_enable_pin && wide_loop_select) [*5] |-> loop_bandwidth == ssr_pkg::BW_250K)
		else $error("wide bandwidth not selected");
	a_spread_on: assert property (spread_enable_pin [*6] |-> spread_active)
		else $error("ramp not running with pin high");
	a_spread_off: assert property (!spread_enable_pin [*6] |-> !spread_active)
		else $error("ramp running with pin low");
	a_step_size: assert property (spread_active && $past(spread_active) && $changed(sdm_numerator) |->
		(sdm_numerator - $past(sdm_numerator) <= 12'h080) || ($past(sdm_numerator) - sdm_numerator <= 12'h080))
		else $error("numerator moved by more than one step");
	a_reacq_pulse: assert property (reacquire_request |=> !reacquire_request)
		else $error("reacquire request longer than one cycle");
	a_reacq_ack: assert property (reacquire_request |-> $rose(sda_oe))
		else $error("reacquire request not at the data ack");
	// data line may only move while the bus clock is low
	a_sda_scl: assert property ($changed(sda_oe) |-> !scl)
		else $error("data line changed with bus clock high");
endmodule : ssr_top_sva
`default_nettype wire

// ### verification/ssr_host_model.sv
// two-wire bus host that drives the register port
`timescale 1ns/10ps
`default_nettype none
module ssr_host_model (
	// clock
	input  wire logic clk_sys,
	// bus wires
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_i
);
	logic host_low;
	// open drain with pull-up: low if either side pulls
	assign sda_i = !(sda_oe || host_low);
	initial begin
		scl = 1'b1;
		host_low = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_clk
	// also serves as repeated start when the clock is low
	task automatic start_c;
		host_low = 1'b0;
		wait_clk(5);
		scl = 1'b1;
		wait_clk(5);
		host_low = 1'b1;
		wait_clk(5);
		scl = 1'b0;
		wait_clk(1);
	endtask : start_c
	task automatic stop_c;
		host_low = 1'b1;
		wait_clk(5);
		scl = 1'b1;
		wait_clk(5);
		host_low = 1'b0;
		wait_clk(5);
	endtask : stop_c
	// nine bits out msb first, nine sampled back; ninth is ack
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			host_low = !tx[i];
			wait_clk(5);
			scl = 1'b1;
			wait_clk(4);
			rx[i] = sda_i;
			wait_clk(1);
			scl = 1'b0;
			wait_clk(1);
		end
	endtask : xfer
endmodule : ssr_host_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench of the spread ramp register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam logic [6:0] DEV = 7'h2A;
	logic             clk_sys, nrst, scl, sda_i, sda_oe, ref_div_clk;
	logic             spread_enable_pin, wide_loop_select;
	logic [5:0]       pll1_fb, pll2_fb;
	logic             ch0_pd, ch1_pd, drain_en, spread_active, host_en, reacq;
	logic [11:0]      sdm_numerator, sdm_divisor;
	ssr_pkg::ssr_bw_t loop_bandwidth;
	logic [7:0]       mdl [256];
	int               n_errors = 0;
	int               checked = 0;
	int               n_pulse = 0;
	int               seed = 86315;

	ssr_top #(.DEV_ADDR(DEV)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_i(sda_i), .sda_o(),
		.sda_oe(sda_oe), .ref_div_clk(ref_div_clk), .spread_enable_pin(spread_enable_pin),
		.wide_loop_select(wide_loop_select), .pll1_feedback_integer(pll1_fb), .channel0_powerdown(ch0_pd),
		.channel1_powerdown(ch1_pd), .charge_drain_enable(drain_en), .pll2_feedback_integer(pll2_fb),
		.sdm_numerator(sdm_numerator), .sdm_divisor(sdm_divisor), .loop_bandwidth(loop_bandwidth),
		.spread_active(spread_active), .host_settings_enable(host_en), .reacquire_request(reacq));
	ssr_host_model i_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda_i(sda_i));

	////////////////////////////////////////////////////////////////////////////
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_n
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d, errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] sub, input logic [7:0] d [$]);
		logic [8:0] r;
		logic [7:0] a;
		a = sub;
		i_host.start_c;
		i_host.xfer({DEV, 1'b0, 1'b1}, r);
		chk("address ack", 12'h000, 12'(r[0]));
		i_host.xfer({sub, 1'b1}, r);
		chk("subaddress ack", 12'h000, 12'(r[0]));
		foreach (d[k]) begin
			i_host.xfer({d[k], 1'b1}, r);
			chk("data ack", 12'h000, 12'(r[0]));
			mdl[a] = d[k];
			a++;
		end
		i_host.stop_c;
		wait_n(4);
	endtask : wr
	task automatic rd(input logic [7:0] sub, input int n);
		logic [8:0] r;
		i_host.start_c;
		i_host.xfer({DEV, 1'b0, 1'b1}, r);
		i_host.xfer({sub, 1'b1}, r);
		i_host.start_c;
		i_host.xfer({DEV, 1'b1, 1'b1}, r);
		chk("read address ack", 12'h000, 12'(r[0]));
		for (int k = 0; k < n; k++) begin
			i_host.xfer({8'hFF, (k == n - 1) ? 1'b1 : 1'b0}, r);
			chk("read data", 12'(mdl[8'(sub + k)]), 12'(r[8:1]));
		end
		i_host.stop_c;
	endtask : rd
	task automatic chk_outs;
		chk("numerator", {mdl[8'h19], mdl[8'h1A][7:4]}, sdm_numerator);
		chk("divisor", {mdl[8'h1A][3:0], mdl[8'h1B]}, sdm_divisor);
		chk("second ratio", 12'(mdl[8'h1C][5:0]), 12'(pll2_fb));
		chk("first ratio", 12'(mdl[8'h18][5:0]), 12'(pll1_fb));
		chk("power drain", 12'(mdl[8'h11][2:0]), {9'h000, drain_en, ch1_pd, ch0_pd});
		chk("host enable", 12'(mdl[8'h40][1]), 12'(host_en));
	endtask : chk_outs
	task automatic ramp(input int periods);
		int base, steps, rdiv, inc, off, cnt, upd;
		logic dn;
		base = {mdl[8'h19], mdl[8'h1A][7:4]};
		steps = {mdl[8'h2B], mdl[8'h2C][7]};
		rdiv = mdl[8'h2C][6:0];
		inc = $signed(mdl[8'h2A]);
		off = 0;
		cnt = 0;
		upd = 0;
		dn = 1'b1;
		// start just after a tick so the latch lands before the next one
		@(posedge ref_div_clk);
		@(negedge clk_sys);
		spread_enable_pin = 1'b1;
		repeat (2 * steps * rdiv * periods) begin
			@(posedge ref_div_clk);
			chk("ramp numerator", 12'(base + off), sdm_numerator);
			cnt++;
			if (cnt == rdiv) begin
				cnt = 0;
				off += dn ? inc : -inc;
				upd++;
				if (upd == steps) begin
					upd = 0;
					dn = !dn;
				end
			end
		end
		wait_n(1);
		chk("spreading", 12'h001, 12'(spread_active));
		chk("spread bandwidth", 12'(ssr_pkg::BW_125K), 12'(loop_bandwidth));
		wide_loop_select = 1'b1;
		wait_n(6);
		chk("wide bandwidth", 12'(ssr_pkg::BW_250K), 12'(loop_bandwidth));
		wide_loop_select = 1'b0;
		spread_enable_pin = 1'b0;
		wait_n(6);
		chk("normal bandwidth", 12'(ssr_pkg::BW_50K), 12'(loop_bandwidth));
		chk("spreading off", 12'h000, 12'(spread_active));
	endtask : ramp

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = !clk_sys;
	end
	// reference clock runs free, offset from the system clock
	initial begin
		ref_div_clk = 1'b0;
		#7;
		forever #100 ref_div_clk = !ref_div_clk;
	end
	// counted on the falling edge, half a cycle after launch, so the one-cycle pulse is seen settled
	always @(negedge clk_sys) if (reacq === 1'b1) n_pulse++;
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		finish_test;
	end
	initial begin
		logic [8:0] r;
		int v;
		nrst = 1'b0;
		spread_enable_pin = 1'b0;
		wide_loop_select = 1'b0;
		foreach (mdl[i]) mdl[i] = 8'h00;
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		wait_n(4);
		chk_outs;
		i_host.start_c;
		i_host.xfer({DEV ^ 7'h01, 1'b0, 1'b1}, r);
		chk("foreign address nack", 12'h001, 12'(r[0]));
		i_host.stop_c;
		wr(8'h19, '{8'h0C, 8'h62, 8'h71, 8'h14});
		chk_outs;
		rd(8'h19, 4);
		rd(8'h50, 1);
		v = $random(seed);
		wr(8'h11, '{8'(v & 7)});
		v = $random(seed);
		wr(8'h18, '{8'(v & 63)});
		wr(8'h40, '{8'h02});
		chk_outs;
		n_pulse = 0;
		wr(8'h1F, '{8'h01});
		wr(8'h1F, '{8'h00});
		chk("reacquire pulses", 12'h001, 12'(n_pulse));
		// deepest step with a single step per half
		wr(8'h2A, '{8'h80, 8'h00, 8'h82});
		ramp(2);
		chk_outs;
		// new settings act after the pin toggles
		v = $random(seed);
		wr(8'h2A, '{8'(-(v & 63)), 8'h01, 8'h83});
		ramp(2);
		chk_outs;
		// mid-run reset with the bus idle: every register back to zero
		nrst = 1'b0;
		foreach (mdl[i]) mdl[i] = 8'h00;
		wait_n(2);
		nrst = 1'b1;
		wait_n(4);
		chk_outs;
		chk("reset bandwidth", 12'(ssr_pkg::BW_50K), 12'(loop_bandwidth));
		finish_test;
	end
endmodule : tb_top
bind ssr_top ssr_top_sva i_sva (.clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_oe(sda_oe),
	.spread_enable_pin(spread_enable_pin), .wide_loop_select(wide_loop_select), .sdm_numerator(sdm_numerator),
	.loop_bandwidth(loop_bandwidth), .spread_active(spread_active), .reacquire_request(reacquire_request));
`default_nettype wire
